// file: dv/watchdog_service_irq_tb.sv
// self-checking bench for the watchdog: bus master tasks, timing table, directed cases
// assumes a zero-wait-state slave; the tick is shortened to four clocks
`timescale 1ns/1ps
module watchdog_service_irq_tb;
	import wdsi_pkg::*;
	localparam int TCK = 4;
	typedef struct {logic [2:0] tsel; int ticks;} wdsi_row_t;
	wdsi_row_t rows [5] = '{'{3'h4, 256}, '{3'h3, 64}, '{3'h2, 16}, '{3'h1, 4}, '{3'h0, 1}};
	logic ref_clk_i = 1'h0;
	logic sys_rst_i = 1'h1;
	logic hsel_i = 1'h0;
	logic hwrite_i = 1'h0;
	logic dbg_attached_i = 1'h0;
	logic [31:0] haddr_i = 32'h0000_0000;
	logic [31:0] hwdata_i = 32'h0000_0000;
	logic [1:0] htrans_i = 2'h0;
	logic [2:0] hsize_i = 3'h2;
	logic hreadyout_o, hresp_o, cpu_reset_o, cpu_irq_o, irq_o;
	logic wd_irq_pending_o, relaxed_mode_status_o, wd_running_status_o;
	logic [31:0] hrdata_o, rd, c1;
	int bad_count = 0;
	int num_checks = 0;
	int n, rst0, rst_cnt;

	always #25 ref_clk_i = ~ref_clk_i;

	wdsi_top #(.TICK_CYC(TCK)) wdsi_top_inst (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .hsel_i(hsel_i),
		.haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hready_i(hreadyout_o),
		.hwdata_i(hwdata_i), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .hrdata_o(hrdata_o),
		.dbg_attached_i(dbg_attached_i), .cpu_reset_o(cpu_reset_o), .cpu_irq_o(cpu_irq_o),
		.wd_irq_pending_o(wd_irq_pending_o), .relaxed_mode_status_o(relaxed_mode_status_o),
		.wd_running_status_o(wd_running_status_o), .irq_o(irq_o));
	wdsi_cpu_model wdsi_cpu_model_inst (.clk_i(ref_clk_i), .rst_i(sys_rst_i), .cpu_reset_i(cpu_reset_o),
		.rst_cnt_o(rst_cnt));

	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// entered right after a rising edge; only the watchdog process ends a stalled wait
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		hsel_i <= 1'h1;
		htrans_i <= 2'h2;
		haddr_i <= {24'h00_0000, a};
		hwrite_i <= wr;
		do @(posedge ref_clk_i); while (hreadyout_o !== 1'h1);
		hsel_i <= 1'h0;
		htrans_i <= 2'h0;
		hwdata_i <= d;
		do @(posedge ref_clk_i); while (hreadyout_o !== 1'h1);
		q = hrdata_o;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'h1, a, d, rd);
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		bus(1'h0, a, 32'h0000_0000, rd);
		chk(rd, exp);
		chk(hresp_o, 32'h0000_0000);
	endtask

	task automatic cmd(input int b);
		wr(OFS_CMD, 32'h0000_0001 << b);
	endtask

	task automatic wait_for(input int sel, input int lim, output int cnt);
		cnt = 0;
		do begin
			@(posedge ref_clk_i);
			cnt++;
		end while (cnt < lim && (sel ? wd_irq_pending_o : cpu_reset_o) !== 1'h1);
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		repeat (40000) @(posedge ref_clk_i);
		bad_count++;
		complete_run();
	end

	initial begin
		repeat (12) @(posedge ref_clk_i);
		sys_rst_i <= 1'h0;
		@(posedge ref_clk_i);
		wr(OFS_CFG, 32'h0000_0010);
		rdchk(OFS_CFG, 32'h0000_0007);
		rdchk(OFS_INT_STAT, 32'h0000_0002);
		wr(OFS_INT_STAT, 32'h0000_0003);
		cmd(CMD_RELAXED);
		wr(OFS_CFG, 32'h0000_0010);
		wr(OFS_CFG, 32'h0000_0031);
		rdchk(OFS_CFG, 32'h0000_0010);
		rdchk(OFS_INT_STAT, 32'h0000_0002);
		@(posedge ref_clk_i);
		chk(relaxed_mode_status_o, 32'h0000_0001);
		chk(wd_running_status_o, 32'h0000_0001);
		$display("mode entry done");
		foreach (rows[i]) begin
			wr(OFS_CFG, {26'h000_0000, 2'h1, 1'h0, rows[i].tsel});
			cmd(CMD_KICK);
			if (rows[i].ticks > 1) begin
				repeat (TCK * rows[i].ticks / 2) @(posedge ref_clk_i);
				cmd(CMD_KICK);
			end
			wait_for(0, 5000, n);
			chk(n >= TCK * (rows[i].ticks - 1) + 1 && n <= TCK * rows[i].ticks + 2, 32'h0000_0001);
			@(posedge ref_clk_i);
			chk(cpu_reset_o, 32'h0000_0000);
			$display("period row %0d done", i);
		end
		// interrupt action with the processor interrupt masked
		cmd(CMD_AUTO_OFF);
		wr(OFS_CFG, 32'h0000_0023);
		wr(OFS_INT_MASK, 32'h0000_0001);
		cmd(CMD_KICK);
		wait_for(1, 400, n);
		chk(cpu_irq_o, 32'h0000_0000);
		chk(irq_o, 32'h0000_0001);
		rdchk(OFS_STATUS, 32'h0000_0107);
		repeat (40) @(posedge ref_clk_i);
		bus(1'h0, OFS_COUNT, 32'h0000_0000, c1);
		cmd(CMD_IRQ_UNMASK);
		@(posedge ref_clk_i);
		chk(cpu_irq_o, 32'h0000_0001);
		cmd(CMD_IRQ_MASK);
		@(posedge ref_clk_i);
		chk(cpu_irq_o, 32'h0000_0000);
		cmd(CMD_IRQ_CLEAR);
		@(posedge ref_clk_i);
		chk(wd_irq_pending_o, 32'h0000_0000);
		bus(1'h0, OFS_COUNT, 32'h0000_0000, rd);
		chk(c1 - rd < 6, 32'h0000_0001);
		wr(OFS_INT_STAT, 32'h0000_0003);
		@(posedge ref_clk_i);
		chk(irq_o, 32'h0000_0000);
		$display("interrupt case done");
		// auto service keeps a 1024-cycle period alive only while the irq enable is on
		wr(OFS_CFG, 32'h0000_0014);
		cmd(CMD_AUTO_ON);
		cmd(CMD_IRQ_UNMASK);
		cmd(CMD_KICK);
		rst0 = rst_cnt;
		repeat (2500) @(posedge ref_clk_i);
		chk(rst_cnt - rst0, 32'h0000_0000);
		cmd(CMD_IRQ_MASK);
		wait_for(0, 1600, n);
		chk(cpu_reset_o, 32'h0000_0001);
		dbg_attached_i <= 1'h1;
		@(posedge ref_clk_i);
		chk(wd_running_status_o, 32'h0000_0000);
		rst0 = rst_cnt;
		repeat (1500) @(posedge ref_clk_i);
		chk(rst_cnt - rst0, 32'h0000_0000);
		dbg_attached_i <= 1'h0;
		$display("auto service case done");
		cmd(CMD_FULL);
		wr(OFS_CFG, 32'h0000_0000);
		cmd(CMD_RELAXED);
		@(posedge ref_clk_i);
		chk(relaxed_mode_status_o, 32'h0000_0000);
		rdchk(OFS_CFG, 32'h0000_0014);
		rdchk(OFS_STATUS, 32'h0000_020C);
		rdchk(8'h18, 32'h0000_0000);
		$display("full safety case done");
		sys_rst_i <= 1'h1;
		repeat (12) @(posedge ref_clk_i);
		sys_rst_i <= 1'h0;
		@(posedge ref_clk_i);
		rdchk(OFS_STATUS, 32'h0000_0008);
		chk(cpu_irq_o, 32'h0000_0000);
		$display("reset case done");
		complete_run();
	end
endmodule

// file: dv/wdsi_cpu_model.sv
// processor-side partner of the watchdog: counts reset pulses it receives
// assumes cpu_reset_i is synchronous to clk_i and pulses for one cycle
`timescale 1ns/1ps
module wdsi_cpu_model (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// watchdog side
	input wire logic cpu_reset_i,
	// observation
	output int rst_cnt_o
);
	// a pulse held longer than one cycle counts more than once, which the bench sees
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rst_cnt_o <= 0;
		end else if (cpu_reset_i === 1'h1) begin
			rst_cnt_o <= rst_cnt_o + 1;
		end
	end
endmodule

// file: logic/wdsi_pkg.sv
// constants, encodings and the state record of the watchdog with service and interrupt control
// assumes a 20 MHz system clock and an AHB-Lite register bus with 32-bit data
package wdsi_pkg;
	// clock and time base
	localparam int unsigned CLK_PERIOD_NS = 50;
	localparam int unsigned TICK_US = 250;
	localparam int unsigned TICK_CYC_DFLT = (TICK_US * 1000) / CLK_PERIOD_NS;
	localparam int unsigned AUTO_KICK_US = 30000;
	localparam logic [6:0] AUTO_KICK_TICKS = 7'(AUTO_KICK_US / TICK_US);
	localparam int unsigned PRESC_W = 16;
	localparam int unsigned CNT_W = 15;

	// register byte offsets
	localparam logic [7:0] OFS_CMD = 8'h00;
	localparam logic [7:0] OFS_CFG = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [7:0] OFS_COUNT = 8'h0C;
	localparam logic [7:0] OFS_INT_STAT = 8'h10;
	localparam logic [7:0] OFS_INT_MASK = 8'h14;

	// command register bits (write one to act)
	localparam int unsigned CMD_KICK = 0;
	localparam int unsigned CMD_AUTO_ON = 1;
	localparam int unsigned CMD_AUTO_OFF = 2;
	localparam int unsigned CMD_IRQ_UNMASK = 3;
	localparam int unsigned CMD_IRQ_MASK = 4;
	localparam int unsigned CMD_IRQ_CLEAR = 5;
	localparam int unsigned CMD_RELAXED = 6;
	localparam int unsigned CMD_FULL = 7;

	// configuration fields
	localparam int unsigned CFG_TSEL_LSB = 0;
	localparam int unsigned CFG_ACT_LSB = 4;

	// status bits
	localparam int unsigned ST_PENDING = 0;
	localparam int unsigned ST_RELAXED = 1;
	localparam int unsigned ST_RUNNING = 2;
	localparam int unsigned ST_AUTO = 3;
	localparam int unsigned ST_IRQ_EN = 4;
	localparam int unsigned ST_MODE_LSB = 8;

	// sticky event bits
	localparam int unsigned EV_EXPIRY = 0;
	localparam int unsigned EV_REFUSED = 1;
	localparam int unsigned EV_W = 2;

	// reset values
	localparam logic [2:0] TSEL_RST = 3'h7;
	localparam logic [31:0] RDATA_RST = 32'h0000_0000;

	typedef enum logic [1:0] {
		mode_preop = 2'b00,
		mode_relaxed = 2'b01,
		mode_full = 2'b10
	} wdsi_mode_t;

	typedef enum logic [1:0] {
		action_none = 2'b00,
		action_cpu_reset = 2'b01,
		action_cpu_irq = 2'b10
	} wdsi_action_t;

	typedef struct packed {
		wdsi_mode_t mode;
		logic auto_kick;
		logic irq_en;
		logic pending;
		wdsi_action_t action;
		logic [2:0] tsel;
		logic [CNT_W-1:0] cnt;
		logic [PRESC_W-1:0] presc;
		logic [6:0] akcnt;
		logic [EV_W-1:0] int_stat;
		logic [EV_W-1:0] int_mask;
		logic cpu_reset;
		logic dp_wr;
		logic [7:0] dp_addr;
		logic [31:0] rdata;
	} wdsi_state_t;
endpackage

// file: logic/wdsi_top.sv
// watchdog timer with service, automatic service, expiry action and interrupt control
// assumes a single AHB-Lite master, inputs synchronous to ref_clk_i, a 20 MHz clock
// Function
// - a service request reloads the counter with the configured period.
// - with auto service on and interrupt enabled, service every 30 ms.
// - auto service is on after reset until turned off.
// - interrupt enable gates propagation and auto service; pending flag still sets and reads.
// - clearing interrupt enable stops forwarding the interrupt to the processor.
// - pending indication reads true while a watchdog interrupt is outstanding.
// - an acknowledge clears the outstanding interrupt indication.
// - acknowledge leaves counter alone; counter restarts itself after expiry.
// - a status bit reads true in relaxed mode, false in full safety.
// - running status is false when action is none or debugger attached.
// - expiry action is one of none, processor reset, processor interrupt.
// - period selectable 0.25, 1, 4, 16, 64, 256, 1024, 4096 ms.
// - full safety mode is kept until power off and refuses changes.
// - pre-operational mode refuses period and action changes.
//
// Local design decisions: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
module wdsi_top #(
	parameter int unsigned TICK_CYC = wdsi_pkg::TICK_CYC_DFLT
) (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	// ahb-lite slave
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic hready_i,
	input wire logic [31:0] hwdata_i,
	output logic hreadyout_o,
	output logic hresp_o,
	output logic [31:0] hrdata_o,
	// debugger presence
	input wire logic dbg_attached_i,
	// processor side
	output logic cpu_reset_o,
	output logic cpu_irq_o,
	// status and system interrupt
	output logic wd_irq_pending_o,
	output logic relaxed_mode_status_o,
	output logic wd_running_status_o,
	output logic irq_o
);
	import wdsi_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// helpers

	// period in 0.25 ms ticks: 1, 4, 16 ... 16384
	function automatic logic [CNT_W-1:0] period_ticks(input logic [2:0] sel);
		logic [CNT_W-1:0] one;
		one = {{(CNT_W-1){1'b0}}, 1'b1};
		return one << {sel, 1'b0};
	endfunction

	function automatic logic is_action(input logic [1:0] a);
		logic ok;
		ok = 1'b0;
		unique case (a)
			action_none, action_cpu_reset, action_cpu_irq: begin
				ok = 1'b1;
			end
			default: begin
				ok = 1'b0;
			end
		endcase
		return ok;
	endfunction

	wdsi_state_t st_r;
	wdsi_state_t st_nxt;

	logic aphase;
	logic wr_cmd;
	logic wr_cfg;
	logic cfg_ok;
	logic [31:0] cmd;
	logic tick;
	logic running;
	logic auto_evt;
	logic kick;
	logic expire;
	logic [EV_W-1:0] events;
	logic [EV_W-1:0] w1c;
	logic [31:0] status_word;
	logic mapped;

	////////////////////////////////////////////////////////////////////////
	// bus decode: zero wait state, always okay

	assign aphase = hsel_i && htrans_i[1] && hready_i;
	assign hreadyout_o = 1'b1;
	assign hresp_o = 1'b0;
	assign hrdata_o = st_r.rdata;
	// only the low 256 bytes decode: above that reads give zero and writes are dropped
	assign mapped = (haddr_i[31:8] == 24'h00_0000);

	assign wr_cmd = st_r.dp_wr && (st_r.dp_addr == OFS_CMD);
	assign wr_cfg = st_r.dp_wr && (st_r.dp_addr == OFS_CFG);
	assign cmd = wr_cmd ? hwdata_i : 32'h0000_0000;

	// changes only in relaxed mode and only with a legal action code
	assign cfg_ok = (st_r.mode == mode_relaxed) && is_action(hwdata_i[CFG_ACT_LSB +: 2]);

	////////////////////////////////////////////////////////////////////////
	// timer events

	assign running = (st_r.action != action_none) && !dbg_attached_i;
	assign tick = (st_r.presc == PRESC_W'(TICK_CYC - 1));
	assign auto_evt = tick && st_r.auto_kick && st_r.irq_en && (st_r.akcnt == AUTO_KICK_TICKS - 7'd1);
	assign kick = cmd[CMD_KICK] || auto_evt;
	// expiry when the counter would reach zero; a kick in the same cycle wins
	assign expire = running && tick && !kick && (st_r.cnt == {{(CNT_W-1){1'b0}}, 1'b1});

	assign status_word = {{(32-ST_MODE_LSB-2){1'b0}}, st_r.mode, 3'h0, st_r.irq_en, st_r.auto_kick,
		running, (st_r.mode == mode_relaxed), st_r.pending};

	////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		st_nxt = st_r;
		events = '0;
		w1c = '0;

		// prescaler runs freely so the tick phase does not depend on software
		st_nxt.presc = tick ? '0 : st_r.presc + PRESC_W'(1);

		if (st_r.auto_kick && st_r.irq_en) begin
			if (tick) begin
				st_nxt.akcnt = auto_evt ? 7'd0 : st_r.akcnt + 7'd1;
			end
		end else begin
			st_nxt.akcnt = 7'd0;
		end

		// counter
		if (kick) begin
			st_nxt.cnt = period_ticks(st_r.tsel);
		end else if (expire) begin
			st_nxt.cnt = period_ticks(st_r.tsel);
		end else if (running && tick) begin
			st_nxt.cnt = st_r.cnt - CNT_W'(1);
		end

		// expiry action, once per expiry
		st_nxt.cpu_reset = 1'b0;
		if (expire) begin
			events[EV_EXPIRY] = 1'b1;
			unique case (st_r.action)
				action_cpu_reset: begin
					st_nxt.cpu_reset = 1'b1;
				end
				action_cpu_irq: begin
					st_nxt.pending = 1'b1;
				end
				default: begin
					st_nxt.cpu_reset = 1'b0;
				end
			endcase
		end
		// acknowledge clears, a simultaneous expiry with the interrupt action wins
		if (cmd[CMD_IRQ_CLEAR] && !(expire && st_r.action == action_cpu_irq)) begin
			st_nxt.pending = 1'b0;
		end

		// auto service and interrupt enable
		if (cmd[CMD_AUTO_ON]) begin
			st_nxt.auto_kick = 1'b1;
		end else if (cmd[CMD_AUTO_OFF]) begin
			st_nxt.auto_kick = 1'b0;
		end
		if (cmd[CMD_IRQ_UNMASK]) begin
			st_nxt.irq_en = 1'b1;
		end else if (cmd[CMD_IRQ_MASK]) begin
			st_nxt.irq_en = 1'b0;
		end

		// safety mode: full safety is a one-way door
		unique case (st_r.mode)
			mode_preop: begin
				if (cmd[CMD_FULL]) begin
					st_nxt.mode = mode_full;
				end else if (cmd[CMD_RELAXED]) begin
					st_nxt.mode = mode_relaxed;
				end
			end
			mode_relaxed: begin
				if (cmd[CMD_FULL]) begin
					st_nxt.mode = mode_full;
				end
			end
			mode_full: begin
				st_nxt.mode = mode_full;
			end
			default: begin
				st_nxt.mode = mode_full;
			end
		endcase

		// configuration
		if (wr_cfg) begin
			if (cfg_ok) begin
				st_nxt.tsel = hwdata_i[CFG_TSEL_LSB +: 3];
				st_nxt.action = wdsi_action_t'(hwdata_i[CFG_ACT_LSB +: 2]);
			end else begin
				events[EV_REFUSED] = 1'b1;
			end
		end

		// sticky events, set wins over write-one-to-clear
		if (st_r.dp_wr && st_r.dp_addr == OFS_INT_STAT) begin
			w1c = hwdata_i[EV_W-1:0];
		end
		st_nxt.int_stat = (st_r.int_stat & ~w1c) | events;
		if (st_r.dp_wr && st_r.dp_addr == OFS_INT_MASK) begin
			st_nxt.int_mask = hwdata_i[EV_W-1:0];
		end

		// bus address phase and read data
		st_nxt.dp_wr = aphase && hwrite_i && mapped;
		st_nxt.dp_addr = aphase ? haddr_i[7:0] : st_r.dp_addr;
		if (aphase && !hwrite_i && mapped) begin
			unique case (haddr_i[7:0])
				OFS_CMD: begin
					st_nxt.rdata = RDATA_RST;
				end
				OFS_CFG: begin
					st_nxt.rdata = {26'h000_0000, st_r.action, 1'b0, st_r.tsel};
				end
				OFS_STATUS: begin
					st_nxt.rdata = status_word;
				end
				OFS_COUNT: begin
					st_nxt.rdata = {{(32-CNT_W){1'b0}}, st_r.cnt};
				end
				OFS_INT_STAT: begin
					st_nxt.rdata = {{(32-EV_W){1'b0}}, st_r.int_stat};
				end
				OFS_INT_MASK: begin
					st_nxt.rdata = {{(32-EV_W){1'b0}}, st_r.int_mask};
				end
				default: begin
					st_nxt.rdata = RDATA_RST;
				end
			endcase
		end else if (aphase) begin
			st_nxt.rdata = RDATA_RST;
		end
	end

	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			st_r <= '{mode: mode_preop, auto_kick: 1'b1, irq_en: 1'b0, pending: 1'b0,
				action: action_none, tsel: TSEL_RST, cnt: period_ticks(TSEL_RST), presc: '0, akcnt: '0,
				int_stat: '0, int_mask: '0, cpu_reset: 1'b0, dp_wr: 1'b0, dp_addr: '0, rdata: RDATA_RST};
		end else begin
			st_r <= st_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs

	assign cpu_reset_o = st_r.cpu_reset;
	assign cpu_irq_o = st_r.pending && st_r.irq_en;
	assign wd_irq_pending_o = st_r.pending;
	assign relaxed_mode_status_o = (st_r.mode == mode_relaxed);
	assign wd_running_status_o = running;
	assign irq_o = |(st_r.int_stat & st_r.int_mask);

	////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (sys_rst_i);

	AST_KICK_RELOAD: assert property (cmd[CMD_KICK] |=> st_r.cnt == period_ticks($past(st_r.tsel)))
		else $error("kick did not reload period");
	AST_AUTO_KICK: assert property (auto_evt |=> st_r.akcnt == 7'd0 && st_r.cnt == period_ticks($past(st_r.tsel)))
		else $error("auto service did not reload");
	AST_AUTO_OFF_ONLY: assert property ($fell(st_r.auto_kick) |-> $past(cmd[CMD_AUTO_OFF]))
		else $error("auto service dropped without command");
	AST_PEND_WHILE_MASKED: assert property (expire && st_r.action == action_cpu_irq |=> wd_irq_pending_o)
		else $error("pending not set on irq expiry");
	AST_MASK_GATES: assert property (cmd[CMD_IRQ_MASK] && !cmd[CMD_IRQ_UNMASK] |=> !cpu_irq_o)
		else $error("irq forwarded while masked");
	AST_PEND_HOLDS: assert property (st_r.pending && !cmd[CMD_IRQ_CLEAR] |=> st_r.pending)
		else $error("pending lost without acknowledge");
	AST_ACK_CLEARS: assert property (cmd[CMD_IRQ_CLEAR] && !expire |=> !wd_irq_pending_o)
		else $error("acknowledge did not clear pending");
	AST_ACK_KEEPS_CNT: assert property (cmd[CMD_IRQ_CLEAR] && !kick && !tick |=> $stable(st_r.cnt))
		else $error("acknowledge changed counter");
	AST_RELAXED_STATUS: assert property (cmd[CMD_FULL] |=> !relaxed_mode_status_o [*2])
		else $error("relaxed status wrong after full safety");
	AST_RUNNING: assert property (!wd_running_status_o && !kick |=> $stable(st_r.cnt))
		else $error("counter moved while watchdog stopped");
	AST_FULL_STICKS: assert property (st_r.mode == mode_full |=> st_r.mode == mode_full && $stable(st_r.tsel))
		else $error("full safety left or changed");
	AST_PREOP_REFUSE: assert property (wr_cfg && st_r.mode == mode_preop |=> $stable(st_r.action) && st_r.int_stat[EV_REFUSED])
		else $error("config accepted in pre-operational mode");
	AST_RESET_PULSE: assert property (expire && st_r.action == action_cpu_reset |=> cpu_reset_o ##1 !cpu_reset_o)
		else $error("reset pulse not exactly one cycle");

	// counter, expiry and interrupt flag
	AST_EXPIRY_RELOAD: assert property (expire |=> st_r.int_stat[EV_EXPIRY] &&
		st_r.cnt == period_ticks($past(st_r.tsel)))
		else $error("expiry did not restart counter or set event");
	AST_DECREMENT: assert property (running && tick && !kick && !expire |=>
		st_r.cnt == $past(st_r.cnt) - CNT_W'(1))
		else $error("counter did not step down on tick");
	AST_PULSE_CAUSE: assert property ($rose(cpu_reset_o) |->
		$past(expire && st_r.action == action_cpu_reset))
		else $error("reset pulse without expiry");
	AST_PEND_CAUSE: assert property ($rose(st_r.pending) |->
		$past(expire && st_r.action == action_cpu_irq))
		else $error("pending set without interrupt expiry");
	AST_UNMASK_FORWARD: assert property (cmd[CMD_IRQ_UNMASK] && st_r.pending && !cmd[CMD_IRQ_CLEAR] |=>
		cpu_irq_o)
		else $error("pending interrupt not forwarded after unmask");
	AST_AUTO_WAITS: assert property (st_r.auto_kick && st_r.irq_en && tick && !auto_evt |=>
		st_r.akcnt == $past(st_r.akcnt) + 7'd1)
		else $error("auto service interval not counted");

	// configuration and safety mode
	AST_CFG_TAKEN: assert property (wr_cfg && cfg_ok |=> st_r.tsel == $past(hwdata_i[CFG_TSEL_LSB +: 3]) &&
		st_r.action == $past(hwdata_i[CFG_ACT_LSB +: 2]))
		else $error("accepted configuration not stored");
	AST_HOLD_CFG: assert property (!wr_cfg |=> $stable(st_r.tsel) && $stable(st_r.action))
		else $error("configuration changed without a write");
	AST_FULL_REFUSE: assert property (wr_cfg && st_r.mode == mode_full |=>
		$stable(st_r.action) && st_r.int_stat[EV_REFUSED])
		else $error("config accepted in full safety mode");
	AST_MODE_ONEWAY: assert property (st_r.mode == mode_relaxed |=> st_r.mode != mode_preop)
		else $error("relaxed mode fell back to pre-operational");
	AST_ACTION_LEGAL: assert property (is_action(st_r.action))
		else $error("illegal expiry action stored");
	AST_MODE_LEGAL: assert property (st_r.mode inside {mode_preop, mode_relaxed, mode_full})
		else $error("illegal safety mode");
endmodule
